// ---- rtl/sysco_move_decode.sv ----
// Decoder and executor of system coprocessor move instructions.
// Summary of operation
// RQ1 - Reads sign-extend bit 31 into upper half.
// RQ2 - Opcode 010000; sub 00000 reads, 00100 writes.
// RQ3 - Register field 11000 selects breakpoint moves.
// RQ4 - Selector 100 write loads data address.
// RQ5 - Selector 110 write loads data value.
// RQ6 - Register field 11001: bit0 counter, 5..1 index.
// RQ7 - Exactly two performance counters, index 0, 1.
// RQ8 - One event control register, index 0, readable.
// RQ9 - Software puts barrier after each coprocessor write.
// RQ10 - Page tag write may precede translation write.
// RQ11 - Page tag write flushes branch target cache.
// RQ12 - Page tag writes only from unmapped/global space.
// RQ13 - No segment attribute change from cached kernel.
// RQ14 - Load-store sync before cache enable changes.
// RQ15 - Counter write while counting gives undefined value.
// RQ16 - Event control write loads index 0 register.
// RQ17 - Reserved zero fields belong to the decode.
`timescale 1ns/1ps
`default_nettype none
`include "sysco_move_consts.svh"

module sysco_move_decode (
	// Clock and reset.
	input wire logic CLK_SYS_IN,
	input wire logic RST_IN,
	// Instruction stream and the source general register contents.
	input wire sysco_move_pkg::instr_s INSTR_IN,
	input wire logic [63:0] RT_DATA_IN,
	// Performance events, one per counter.
	input wire logic [1:0] PERF_EVENT_IN,
	// Generic coprocessor register file.
	input wire logic [31:0] COP_RD_DATA_IN,
	output logic COP_RD_EN_OUT,
	output logic [4:0] COP_RD_ADDR_OUT,
	output sysco_move_pkg::cop_wr_s COP_WR_OUT,
	// General register write-back.
	output sysco_move_pkg::gpr_wb_s GPR_WB_OUT,
	// Side effects towards the rest of the core.
	output logic BRANCH_TARGET_CACHE_FLUSH_OUT,
	output logic TLB_INDEXED_WR_OUT,
	output logic TLB_RANDOM_WR_OUT,
	output logic OTHER_INSTR_OUT,
	// Register contents seen by the breakpoint and counting logic.
	output sysco_move_pkg::bkpt_regs_s BKPT_REGS_OUT,
	output logic [31:0] PERF_CTRL_OUT,
	output logic [1:0][31:0] PERF_COUNT_OUT
);
	import sysco_move_pkg::*;

	// Registered state and its next value.
	state_s state;
	state_s next_state;

	// Instruction fields.
	logic [31:0] iw;
	logic is_cop;
	logic is_from;
	logic is_to;
	logic [4:0] rd;
	logic [4:0] perf_idx;
	logic dbg_move;
	logic perf_move;
	logic gen_move;
	logic tlb_move;

	// Sign extension of a 32-bit coprocessor word to a general register.
	function automatic logic [63:0] sext(input logic [31:0] w);
		sext = {{32{w[31]}}, w}; // [RQ1]
	endfunction

	// Only the documented selectors name a breakpoint register.
	function automatic logic bkpt_sel_ok(input logic [2:0] s);
		bkpt_sel_ok = (s != 3'h1); // [RQ3]
	endfunction

	// Breakpoint register read by selector.
	function automatic logic [31:0] bkpt_read(input bkpt_regs_s b, input logic [2:0] s);
		case (s)
			`SEL_BKPT_CTRL: bkpt_read = b.ctrl;
			`SEL_IADDR: bkpt_read = b.iaddr;
			`SEL_IADDR_MASK: bkpt_read = b.iaddr_mask;
			`SEL_DADDR: bkpt_read = b.daddr;
			`SEL_DADDR_MASK: bkpt_read = b.daddr_mask;
			`SEL_DVALUE: bkpt_read = b.dvalue;
			`SEL_DVALUE_MASK: bkpt_read = b.dvalue_mask;
			default: bkpt_read = `REG_RESET;
		endcase
	endfunction

	// Field split and pattern match; reserved fields must be zero to count as a move.
	always_comb begin
		iw = INSTR_IN.word;
		rd = iw[`RD_MSB:`RD_LSB];
		perf_idx = iw[`PERF_IDX_MSB:`PERF_IDX_LSB];
		is_cop = INSTR_IN.valid && (iw[`OPC_MSB:`OPC_LSB] == `OPC_SYS_COPROC); // [RQ2]
		is_from = is_cop && (iw[`SUB_MSB:`SUB_LSB] == `SUB_MOVE_FROM); // [RQ2]
		is_to = is_cop && (iw[`SUB_MSB:`SUB_LSB] == `SUB_MOVE_TO); // [RQ2]
		// Breakpoint moves need bits 10..3 clear.
		dbg_move = (rd == `RD_DEBUG) && (iw[10:3] == 8'h00) && bkpt_sel_ok(iw[2:0]); // [RQ3] [RQ17]
		// Performance moves need bits 10..6 clear.
		perf_move = (rd == `RD_PERF) && (iw[10:6] == 5'h00); // [RQ6] [RQ17]
		// Generic moves need bits 10..0 clear and leave the two class values to the above.
		gen_move = (iw[10:0] == 11'h000) && (rd != `RD_DEBUG) && (rd != `RD_PERF); // [RQ17]
		// Translation writes need bits 20..6 clear.
		tlb_move = is_cop && (iw[`SUB_MSB:`SUB_LSB] == `SUB_CTRL) && (iw[20:6] == 15'h0000)
			&& ((iw[`FUNCT_MSB:0] == `FN_TLB_INDEXED) || (iw[`FUNCT_MSB:0] == `FN_TLB_RANDOM));
	end

	// Next-state logic: stage one captures the decode, stage two returns read data.
	always_comb begin
		next_state = state;
		next_state.s1_op = OP_NONE;
		next_state.cop_rd_en = 1'b0;
		next_state.wb.valid = 1'b0;
		next_state.cop_wr.valid = 1'b0;
		next_state.branch_target_cache_flush = 1'b0;
		next_state.tlb_indexed = 1'b0;
		next_state.tlb_random = 1'b0;
		next_state.other_instr = 1'b0;
		// Counters advance on their events while counting is enabled.
		for (int i = 0; i < 2; i++) begin
			if (state.perf_ctrl[`PERF_ENABLE_BIT] && PERF_EVENT_IN[i]) begin
				next_state.perf_cnt[i] = state.perf_cnt[i] + 32'h0000_0001;
			end
		end
		// Stage two: every read lands two edges after it was taken, so reads never collide.
		if (state.s1_op != OP_NONE) begin
			next_state.wb.valid = 1'b1;
			next_state.wb.index = state.s1_rt;
			case (state.s1_op)
				OP_RD_GEN: begin
					next_state.wb.data = sext(COP_RD_DATA_IN); // [RQ1]
				end
				OP_RD_BKPT: begin
					next_state.wb.data = sext(bkpt_read(state.bkpt, state.s1_idx[2:0])); // [RQ1] [RQ3]
				end
				OP_RD_PERF_CNT: begin
					// Indices past the two counters read as zero.
					if (state.s1_idx < `PERF_NUM_COUNTERS) begin
						next_state.wb.data = sext(state.perf_cnt[state.s1_idx[0]]); // [RQ7]
					end else begin
						next_state.wb.data = 64'h0;
					end
				end
				OP_RD_PERF_CTRL: begin
					// Only index 0 exists; others read as zero.
					if (state.s1_idx == `PERF_CTRL_INDEX) begin
						next_state.wb.data = sext(state.perf_ctrl); // [RQ8]
					end else begin
						next_state.wb.data = 64'h0;
					end
				end
				default: begin
					next_state.wb.data = 64'h0;
				end
			endcase
		end
		// Stage one: decode the incoming instruction.
		if (is_from && (dbg_move || perf_move || gen_move)) begin
			next_state.s1_rt = iw[`RT_MSB:`RT_LSB];
			if (dbg_move) begin
				next_state.s1_op = OP_RD_BKPT;
				next_state.s1_idx = {2'h0, iw[`SEL_MSB:0]};
			end else if (perf_move) begin
				next_state.s1_op = iw[`PERF_CNT_BIT] ? OP_RD_PERF_CNT : OP_RD_PERF_CTRL; // [RQ6]
				next_state.s1_idx = perf_idx;
			end else begin
				// The generic file is addressed now and answers in the next cycle.
				next_state.s1_op = OP_RD_GEN;
				next_state.s1_idx = rd;
				next_state.cop_rd_en = 1'b1;
			end
		end else if (is_to && dbg_move) begin
			// Breakpoint writes take the low word of the source register.
			case (iw[`SEL_MSB:0])
				`SEL_BKPT_CTRL: next_state.bkpt.ctrl = RT_DATA_IN[31:0]; // [RQ3]
				`SEL_IADDR: next_state.bkpt.iaddr = RT_DATA_IN[31:0]; // [RQ3]
				`SEL_IADDR_MASK: next_state.bkpt.iaddr_mask = RT_DATA_IN[31:0]; // [RQ3]
				`SEL_DADDR: next_state.bkpt.daddr = RT_DATA_IN[31:0]; // [RQ4]
				`SEL_DADDR_MASK: next_state.bkpt.daddr_mask = RT_DATA_IN[31:0];
				`SEL_DVALUE: next_state.bkpt.dvalue = RT_DATA_IN[31:0]; // [RQ5]
				`SEL_DVALUE_MASK: next_state.bkpt.dvalue_mask = RT_DATA_IN[31:0]; // [RQ3]
				default: next_state.bkpt = state.bkpt;
			endcase
		end else if (is_to && perf_move) begin
			if (iw[`PERF_CNT_BIT]) begin
				// A write overrides the increment of the same cycle; writing while
				// counting is left to software to avoid, the result is just the load.
				if (perf_idx < `PERF_NUM_COUNTERS) begin
					next_state.perf_cnt[perf_idx[0]] = RT_DATA_IN[31:0]; // [RQ7] [RQ15]
				end
			end else if (perf_idx == `PERF_CTRL_INDEX) begin
				next_state.perf_ctrl = RT_DATA_IN[31:0]; // [RQ16]
			end
		end else if (is_to && gen_move) begin
			// Generic writes go out to the register file; the barrier after them is software's.
			next_state.cop_wr.valid = 1'b1; // [RQ9]
			next_state.cop_wr.addr = rd;
			next_state.cop_wr.data = RT_DATA_IN[31:0];
			// Changing the page tag makes cached branch targets stale.
			next_state.branch_target_cache_flush = (rd == `RD_VIRTUAL_PAGE_TAG); // [RQ11]
		end else if (tlb_move) begin
			// Same pipeline depth as the tag write, so a back-to-back translation write
			// is issued only after the tag write has reached the register file.
			next_state.tlb_indexed = (iw[`FUNCT_MSB:0] == `FN_TLB_INDEXED); // [RQ10]
			next_state.tlb_random = (iw[`FUNCT_MSB:0] == `FN_TLB_RANDOM); // [RQ10]
		end else if (INSTR_IN.valid) begin
			// Anything else, including near misses on reserved fields, is not ours.
			next_state.other_instr = 1'b1; // [RQ17]
		end
	end

	// State register with synchronous reset.
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// Outputs are plain wires from the state flip-flops.
	assign COP_RD_EN_OUT = state.cop_rd_en;
	assign COP_RD_ADDR_OUT = state.s1_idx;
	assign COP_WR_OUT = state.cop_wr;
	assign GPR_WB_OUT = state.wb;
	assign BRANCH_TARGET_CACHE_FLUSH_OUT = state.branch_target_cache_flush;
	assign TLB_INDEXED_WR_OUT = state.tlb_indexed;
	assign TLB_RANDOM_WR_OUT = state.tlb_random;
	assign OTHER_INSTR_OUT = state.other_instr;
	assign BKPT_REGS_OUT = state.bkpt;
	assign PERF_CTRL_OUT = state.perf_ctrl;
	assign PERF_COUNT_OUT = state.perf_cnt;

	// Checks on the decoder's own outputs.
	// All of them run on the core clock and are quiet while reset is held.
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (RST_IN);

	// Every write-back carries a true sign copy in its upper half.
	AST_SIGN_EXT: assert property ( // [RQ1]
		GPR_WB_OUT.valid |-> GPR_WB_OUT.data[63:32] == {32{GPR_WB_OUT.data[31]}}
	) else $error("upper half not sign copy");

	// A generic read addresses the file first and returns its answer a cycle later.
	AST_GEN_READ: assert property ( // [RQ2]
		is_from && gen_move |=> COP_RD_EN_OUT && COP_RD_ADDR_OUT == $past(rd)
		##1 GPR_WB_OUT.valid && GPR_WB_OUT.data[31:0] == $past(COP_RD_DATA_IN)
	) else $error("generic read not returned");

	// Every decoded read writes back to the general register it names.
	AST_WB_INDEX: assert property ( // [RQ2]
		is_from && (dbg_move || perf_move || gen_move) |-> ##2
		GPR_WB_OUT.valid && GPR_WB_OUT.index == $past(iw[`RT_MSB:`RT_LSB], 2)
	) else $error("read write-back index wrong");

	// An instruction address mask read returns the mask register as it stood one cycle before.
	AST_BKPT_READ: assert property ( // [RQ3]
		is_from && dbg_move && iw[2:0] == `SEL_IADDR_MASK |-> ##2
		GPR_WB_OUT.data[31:0] == $past(BKPT_REGS_OUT.iaddr_mask)
	) else $error("breakpoint mask read wrong");

	// Data address breakpoint takes the low source word.
	AST_DADDR_WR: assert property ( // [RQ4]
		is_to && dbg_move && iw[2:0] == `SEL_DADDR |=>
		BKPT_REGS_OUT.daddr == $past(RT_DATA_IN[31:0])
	) else $error("data address not loaded");

	// Data value breakpoint takes the low source word.
	AST_DVALUE_WR: assert property ( // [RQ5]
		is_to && dbg_move && iw[2:0] == `SEL_DVALUE |=>
		BKPT_REGS_OUT.dvalue == $past(RT_DATA_IN[31:0])
	) else $error("data value not loaded");

	// A counter index past the two that exist still answers, with zero.
	AST_PERF_BAD_IDX: assert property ( // [RQ7]
		is_from && perf_move && iw[0] && perf_idx >= `PERF_NUM_COUNTERS |-> ##2
		GPR_WB_OUT.valid && GPR_WB_OUT.data == 64'h0
	) else $error("missing counter read nonzero");

	// The second counter is loaded by a write to index 1.
	AST_PERF_CNT_WR: assert property ( // [RQ7]
		is_to && perf_move && iw[0] && perf_idx == 5'h01 |=>
		PERF_COUNT_OUT[1] == $past(RT_DATA_IN[31:0])
	) else $error("counter one not loaded");

	// Event control reads return the register of the cycle before the answer.
	AST_PERF_CTRL_RD: assert property ( // [RQ8]
		is_from && perf_move && !iw[0] && perf_idx == `PERF_CTRL_INDEX |-> ##2
		GPR_WB_OUT.data[31:0] == $past(PERF_CTRL_OUT)
	) else $error("event control read wrong");

	// Event control writes land at the next edge.
	AST_PERF_CTRL_WR: assert property ( // [RQ16]
		is_to && perf_move && !iw[0] && perf_idx == `PERF_CTRL_INDEX |=>
		PERF_CTRL_OUT == $past(RT_DATA_IN[31:0])
	) else $error("event control not loaded");

	// A page tag write flushes the branch target cache with the write itself.
	AST_BRANCH_TARGET_CACHE_FLUSH: assert property ( // [RQ11]
		is_to && gen_move && rd == `RD_VIRTUAL_PAGE_TAG |=>
		BRANCH_TARGET_CACHE_FLUSH_OUT && COP_WR_OUT.valid
	) else $error("no flush on tag write");

	// A flush never comes without a tag write, so unrelated writes keep the cache.
	AST_FLUSH_ONLY_TAG: assert property ( // [RQ11]
		BRANCH_TARGET_CACHE_FLUSH_OUT |-> COP_WR_OUT.valid && COP_WR_OUT.addr == `RD_VIRTUAL_PAGE_TAG
	) else $error("flush without tag write");

	// The tag write reaches the file one cycle before the translation write leaves.
	AST_TAG_THEN_TLB: assert property ( // [RQ10]
		is_to && gen_move && rd == `RD_VIRTUAL_PAGE_TAG ##1 tlb_move |->
		COP_WR_OUT.valid ##1 (TLB_INDEXED_WR_OUT || TLB_RANDOM_WR_OUT) && !COP_WR_OUT.valid
	) else $error("tlb write not after tag");

	// Foreign opcodes raise the other-instruction flag and leave the coprocessor write port alone.
	AST_OTHER: assert property ( // [RQ17]
		INSTR_IN.valid && !is_cop |=> OTHER_INSTR_OUT && !COP_WR_OUT.valid
	) else $error("foreign op treated as move");

	// Main scenarios that a run should reach.
	COV_BKPT_RW: cover property (is_to && dbg_move ##1 is_from && dbg_move);
	COV_PERF_COUNT: cover property (PERF_CTRL_OUT[`PERF_ENABLE_BIT] && PERF_EVENT_IN[1]);
	COV_TAG_TLB: cover property (BRANCH_TARGET_CACHE_FLUSH_OUT ##1 TLB_INDEXED_WR_OUT);
	// A negative word must come back through the sign extension.
	COV_NEG_READ: cover property (GPR_WB_OUT.valid && GPR_WB_OUT.data[63]);
	// The random translation write is a separate decode path.
	COV_TLB_RANDOM: cover property (TLB_RANDOM_WR_OUT);
endmodule

`default_nettype wire

// ---- rtl/sysco_move_consts.svh ----
// Encoding constants, field positions and reset values of the system coprocessor move decoder.
`ifndef SYSCO_MOVE_CONSTS_SVH
`define SYSCO_MOVE_CONSTS_SVH

// Primary opcode field and its system coprocessor value.
`define OPC_MSB 31
`define OPC_LSB 26
`define OPC_SYS_COPROC 6'h10
// Sub-operation field and its values.
`define SUB_MSB 25
`define SUB_LSB 21
`define SUB_MOVE_FROM 5'h00
`define SUB_MOVE_TO 5'h04
`define SUB_CTRL 5'h10
// General register and coprocessor register fields.
`define RT_MSB 20
`define RT_LSB 16
`define RD_MSB 15
`define RD_LSB 11
// Class values in the register field for debug and performance moves.
`define RD_DEBUG 5'h18
`define RD_PERF 5'h19
// Virtual-page-tag register number inside the generic register file.
`define RD_VIRTUAL_PAGE_TAG 5'h0a
// Breakpoint selectors in bits 2..0.
`define SEL_MSB 2
`define SEL_BKPT_CTRL 3'h0
`define SEL_IADDR 3'h2
`define SEL_IADDR_MASK 3'h3
`define SEL_DADDR 3'h4
`define SEL_DADDR_MASK 3'h5
`define SEL_DVALUE 3'h6
`define SEL_DVALUE_MASK 3'h7
// Performance move fields: index in bits 5..1, counter flag in bit 0.
`define PERF_IDX_MSB 5
`define PERF_IDX_LSB 1
`define PERF_CNT_BIT 0
`define PERF_NUM_COUNTERS 5'h02
`define PERF_CTRL_INDEX 5'h00
// Counting enable bit inside the event control register.
`define PERF_ENABLE_BIT 31
// Translation write function field end and its two function codes.
`define FUNCT_MSB 5
`define FN_TLB_INDEXED 6'h02
`define FN_TLB_RANDOM 6'h06
// Reset value of every register held here.
`define REG_RESET 32'h0000_0000

`endif

// ---- rtl/sysco_move_pkg.sv ----
// Types shared by the system coprocessor move decoder and its users.
package sysco_move_pkg;
	// Which read is pending in the first stage.
	typedef enum logic [2:0] {OP_NONE, OP_RD_GEN, OP_RD_BKPT, OP_RD_PERF_CNT, OP_RD_PERF_CTRL} rd_op_e;
	// Incoming instruction with its valid flag.
	typedef struct packed {logic valid; logic [31:0] word;} instr_s;
	// Write-back to the general register file.
	typedef struct packed {logic valid; logic [4:0] index; logic [63:0] data;} gpr_wb_s;
	// Write into the generic coprocessor register file.
	typedef struct packed {logic valid; logic [4:0] addr; logic [31:0] data;} cop_wr_s;
	// Breakpoint register set.
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] iaddr;
		logic [31:0] iaddr_mask;
		logic [31:0] daddr;
		logic [31:0] daddr_mask;
		logic [31:0] dvalue;
		logic [31:0] dvalue_mask;
	} bkpt_regs_s;
	// Whole state of the decoder.
	typedef struct packed {
		rd_op_e s1_op;
		logic [4:0] s1_rt;
		logic [4:0] s1_idx;
		logic cop_rd_en;
		gpr_wb_s wb;
		cop_wr_s cop_wr;
		logic branch_target_cache_flush;
		logic tlb_indexed;
		logic tlb_random;
		logic other_instr;
		bkpt_regs_s bkpt;
		logic [31:0] perf_ctrl;
		logic [1:0][31:0] perf_cnt;
	} state_s;
endpackage

// ---- verification/tb_sysco_move.sv ----
// Self-checking testbench of the system coprocessor move decoder.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import sysco_move_pkg::*;
	// Clock, reset and stimulus; every input but cop_rd_data has a value at time zero.
	logic clk = 1'b0;
	logic rst = 1'b1;
	instr_s instr = '0;
	logic [63:0] rt_data = '0;
	logic [1:0] perf_event = '0;
	logic [31:0] cop_rd_data;
	// Outputs of the decoder.
	logic cop_rd_en;
	logic [4:0] cop_rd_addr;
	cop_wr_s cop_wr;
	gpr_wb_s gpr_wb;
	logic branch_target_cache_flush;
	logic tlb_indexed;
	logic tlb_random;
	logic other_instr;
	bkpt_regs_s bkpt;
	logic [31:0] perf_ctrl;
	logic [1:0][31:0] perf_count;
	// Counters of the run.
	int bad_count = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [31:0] v;
	logic [4:0] ga [2] = '{5'h05, 5'h10};
	logic [31:0] bad_words [4] = '{32'h4300_c001, 32'h4000_c008, 32'h4080_1c00, 32'h4080_c841};

	sysco_move_decode sysco_move_decode_i (
		.CLK_SYS_IN(clk), .RST_IN(rst), .INSTR_IN(instr), .RT_DATA_IN(rt_data),
		.PERF_EVENT_IN(perf_event), .COP_RD_DATA_IN(cop_rd_data),
		.COP_RD_EN_OUT(cop_rd_en), .COP_RD_ADDR_OUT(cop_rd_addr), .COP_WR_OUT(cop_wr),
		.GPR_WB_OUT(gpr_wb), .BRANCH_TARGET_CACHE_FLUSH_OUT(branch_target_cache_flush), .TLB_INDEXED_WR_OUT(tlb_indexed),
		.TLB_RANDOM_WR_OUT(tlb_random), .OTHER_INSTR_OUT(other_instr),
		.BKPT_REGS_OUT(bkpt), .PERF_CTRL_OUT(perf_ctrl), .PERF_COUNT_OUT(perf_count)
	);

	// Generic register file stand-in; the sign bit differs between the two addresses used.
	function automatic logic [31:0] file_word(input logic [4:0] a);
		return 32'h1234_5600 ^ {a, 27'h0} ^ {27'h0, a};
	endfunction
	assign cop_rd_data = file_word(cop_rd_addr);

	// Builds a move word; the general register is always number 7.
	function automatic logic [31:0] enc(input logic [4:0] sub, input logic [4:0] rd,
		input logic [10:0] low);
		return {6'h10, sub, 5'd7, rd, low};
	endfunction

	// Expected read-back: bit 31 copied into the upper half.
	function automatic logic [63:0] sext(input logic [31:0] w);
		return {{32{w[31]}}, w};
	endfunction

	// Picks the breakpoint register that a selector names.
	function automatic logic [31:0] bkpt_field(input logic [2:0] sel);
		case (sel)
			3'h0: return bkpt.ctrl;
			3'h2: return bkpt.iaddr;
			3'h3: return bkpt.iaddr_mask;
			3'h4: return bkpt.daddr;
			3'h5: return bkpt.daddr_mask;
			3'h6: return bkpt.dvalue;
			default: return bkpt.dvalue_mask;
		endcase
	endfunction

	// Compares and reports at once; bits must match exactly, so an unknown matches only an unknown.
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Issues one instruction alone and returns one cycle after it was taken.
	task automatic exec(input logic [31:0] w, input logic [63:0] d);
		@(posedge clk);
		instr <= '{1'b1, w};
		rt_data <= d;
		@(posedge clk);
		instr.valid <= 1'b0;
		#1;
	endtask

	// Issues two instructions back to back; the caller drops valid afterwards.
	task automatic pair(input logic [31:0] w1, input logic [31:0] w2, input logic [63:0] d);
		@(posedge clk);
		instr <= '{1'b1, w1};
		rt_data <= d;
		@(posedge clk);
		instr <= '{1'b1, w2};
		#1;
	endtask

	// A read answers two cycles after it is taken, so the write-back is checked then.
	task automatic rd_chk(input logic [31:0] w, input logic [31:0] e);
		exec(w, 64'h0);
		@(posedge clk);
		#1;
		chk({gpr_wb.valid, gpr_wb.index}, {1'b1, 5'd7});
		chk(gpr_wb.data, sext(e));
	endtask

	// Closing report, reached from the main sequence or the timeout.
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Free-running clock; a hung handshake is cut off by the cycle ceiling.
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			bad_count++;
			summarize();
		end
	end

	// Main sequence.
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk({62'h0, |bkpt, |perf_count}, 64'h0);
		// Every breakpoint selector, written then read, with both signs of bit 31.
		for (int i = 0; i < 8; i++) begin
			if (i == 1) continue;
			v = {i[2:0] ^ 3'h5, 29'h0bad_f00 + 29'(i)};
			exec(enc(5'h04, 5'h18, {8'h0, i[2:0]}), {32'hdead_beef, v});
			chk(bkpt_field(i[2:0]), v);
			rd_chk(enc(5'h00, 5'h18, {8'h0, i[2:0]}), v);
		end
		// A read right behind a write of the same register sees the new value.
		pair(enc(5'h04, 5'h18, 11'h004), enc(5'h00, 5'h18, 11'h004), {32'h0, 32'hf00d_0044});
		@(posedge clk);
		instr.valid <= 1'b0;
		#1;
		chk(bkpt.daddr, 32'hf00d_0044);
		@(posedge clk);
		#1;
		chk(gpr_wb.data, 64'hffff_ffff_f00d_0044);
		// Generic reads go through the register file port.
		for (int i = 0; i < 2; i++) begin
			exec(enc(5'h00, ga[i], 11'h0), 64'h0);
			chk({cop_rd_en, cop_rd_addr}, {1'b1, ga[i]});
			@(posedge clk);
			#1;
			chk(gpr_wb.data, sext(file_word(ga[i])));
		end
		// A plain generic write does not flush the branch target cache.
		exec(enc(5'h04, 5'h03, 11'h0), {32'hffff_ffff, 32'h0000_abcd});
		chk({other_instr, branch_target_cache_flush, cop_wr.valid, cop_wr.addr}, {3'b001, 5'h03});
		chk(cop_wr.data, 32'h0000_abcd);
		// Page tag write followed directly by each translation write.
		for (int i = 0; i < 2; i++) begin
			pair(enc(5'h04, 5'h0a, 11'h0), {16'h4200, 10'h0, 3'h0, i[0], 2'h2},
				{32'h0, 32'hc000_1234});
			chk({branch_target_cache_flush, cop_wr.valid, cop_wr.addr}, {2'b11, 5'h0a});
			chk(cop_wr.data, 32'hc000_1234);
			@(posedge clk);
			instr.valid <= 1'b0;
			#1;
			chk({branch_target_cache_flush, tlb_indexed, tlb_random}, {2'b00, i[0]} | {1'b0, ~i[0], 1'b0});
		end
		// Nonzero reserved fields and an undefined sub-operation field are other instructions.
		for (int i = 0; i < 4; i++) begin
			exec(bad_words[i], 64'h0);
			chk(other_instr, 1'b1);
			@(posedge clk);
			#1;
			chk({gpr_wb.valid, cop_wr.valid}, 2'b00);
		end
		chk(bkpt.ctrl, 32'ha000_0000 + 32'h0bad_f00);
		// Performance moves; counters are loaded only while counting is off.
		exec(enc(5'h04, 5'h19, 11'h000), {32'h0, 32'h0000_00ff});
		chk(perf_ctrl, 32'h0000_00ff);
		exec(enc(5'h04, 5'h19, 11'h001), {32'h1, 32'h8000_0010});
		exec(enc(5'h04, 5'h19, 11'h003), {32'h1, 32'h0000_0020});
		exec(enc(5'h04, 5'h19, 11'h005), {32'h1, 32'h5555_5555});
		chk(perf_count, {32'h0000_0020, 32'h8000_0010});
		rd_chk(enc(5'h00, 5'h19, 11'h001), 32'h8000_0010);
		rd_chk(enc(5'h00, 5'h19, 11'h003), 32'h0000_0020);
		rd_chk(enc(5'h00, 5'h19, 11'h005), 32'h0);
		rd_chk(enc(5'h00, 5'h19, 11'h000), 32'h0000_00ff);
		rd_chk(enc(5'h00, 5'h19, 11'h002), 32'h0);
		// Counting enabled for three event cycles on counter 0 only.
		exec(enc(5'h04, 5'h19, 11'h000), {32'h0, 32'h8000_00ff});
		@(posedge clk);
		perf_event <= 2'b01;
		repeat (3) @(posedge clk);
		perf_event <= 2'b00;
		@(posedge clk);
		#1;
		chk(perf_count, {32'h0000_0020, 32'h8000_0013});
		exec(enc(5'h04, 5'h19, 11'h000), 64'h0);
		summarize();
	end
endmodule

`default_nettype wire
